/* File: rtl/setpoint_logic_controller.sv */
// Setpoint logical controller with flags, interval timers and counters
// Functional notes
// RULE1 - Sixteen setpoints, each with its own operate and release delay.
// RULE2 - Each setpoint evaluates up to four triggers joined by OR or AND.
// RULE3 - An operating setpoint runs up to four actions: relay, counter, record or flag.
// RULE4 - Trigger relation is less-equal, greater-equal, equal, ON or OFF.
// RULE5 - Analog triggers use operate and release thresholds; digital ignore them.
// RULE6 - Operate waits a programmable delay of up to 10000 s in ms.
// RULE7 - Release waits a programmable delay of up to 10000 s.
// RULE8 - All setpoints are scanned once per half line cycle.
// RULE9 - After reset setpoint one fires data logs one and two every 15 min.
// RULE10 - Setpoint sixteen only accepts its time limit, 1 to 60 minutes.
// RULE11 - Left to right evaluation; a true OR term overrides earlier false.
// RULE12 - A false AND term overrides an earlier true result.
// RULE13 - Software gives a valid release limit for less-equal or greater-equal.
// RULE14 - Binary triggers are tested for set or cleared state.
// RULE15 - Static events are levels held while their condition lasts.
// RULE16 - A pulsed event is raised once per rising edge of its source.
// RULE17 - Pulsed events are cleared at the end of every scan.
// RULE18 - Eight event flags set, cleared and tested by setpoints or software.
// RULE19 - Four free running interval timers emit pulsed events on expiry.
// RULE20 - A setpoint using a timer restarts it when the setpoint operates.
// RULE21 - Status changes only after conditions held for the whole delay.
// RULE22 - Delays are truncated to whole scan periods.
// RULE23 - Operated status is latched in an alarm latch until cleared.
// RULE24 - A timer with zero period is stopped.
// RULE25 - The first active trigger seeds the expression value.
// RULE26 - Greater-equal stays true until the value falls to the release limit.
`include "slc_cfg.svh"
module setpoint_logic_controller import slc_pkg::*; #(
	parameter int N_SP = 16,
	parameter int N_ANALOG = 8,
	parameter int SCAN_60_CYCLES = `SLC_SCAN_60_NS / `SLC_CLK_NS,
	parameter int SCAN_50_CYCLES = `SLC_SCAN_50_NS / `SLC_CLK_NS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [9:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Event sources
	input wire logic [15:0] din,
	input wire logic [7:0] pulse_src,
	input wire logic [N_ANALOG*32-1:0] analog_val,
	input wire logic [5:0] minute_of_hour,
	// Action outputs
	output logic [7:0] relay_out,
	output logic [15:0] rec_trig,
	output logic [N_SP-1:0] sp_status
);
	localparam int NT = N_SP * 4;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [NT-1:0][15:0] tctl;
		logic [NT-1:0][31:0] top;
		logic [NT-1:0][31:0] trel;
		logic [NT-1:0] hyst;
		logic [NT-1:0][6:0] act;
		logic [N_SP-1:0][23:0] dop;
		logic [N_SP-1:0][23:0] drel;
		logic [N_SP-1:0][23:0] elap;
		logic [N_SP-1:0] status;
		logic [N_SP-1:0] alarm;
		logic [3:0][26:0] tper;
		logic [3:0][26:0] tel;
		logic [3:0] tpend;
		logic [7:0] flags;
		logic [7:0] ppend;
		logic [7:0] pprev;
		logic [7:0][31:0] cnt;
		logic line50;
		logic [16:0] scnt;
		logic [7:0] relay;
		logic [15:0] rec;
		logic [31:0] rdata;
	} state_type;

	function automatic state_type init_state();
		state_type s;
		s = '0;
		for (int i = 0; i < NT; i++) begin
			s.tctl[i] = `SLC_RST_TCTL;
		end
		s.tctl[0] = `SLC_RST_TIME_TCTL;
		s.top[0] = `SLC_RST_TIME_MIN;
		s.act[0] = `SLC_RST_ACT_REC0;
		s.act[1] = `SLC_RST_ACT_REC1;
		s.tctl[NT-4] = `SLC_RST_TIME_TCTL;
		s.top[NT-4] = `SLC_RST_TIME_MIN;
		s.act[NT-4] = `SLC_RST_ACT_REC11;
		return s;
	endfunction

	function automatic logic hit(logic [9:0] a, logic [9:0] base, int n);
		return (a >= base) && ({22'h0, a} < {22'h0, base} + 32'(n));
	endfunction

	localparam state_type RESET_ST = init_state();

	state_type st;
	state_type next_st;
	logic scan;
	logic [7:0] rise;
	logic [4:0] step;

	assign scan = 32'(st.scnt) == (st.line50 ? SCAN_50_CYCLES - 1 :
		SCAN_60_CYCLES - 1); // see RULE8
	assign rise = pulse_src & ~st.pprev;
	assign step = st.line50 ? 5'(`SLC_SCAN_50_MS) : 5'(`SLC_SCAN_60_MS);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic [9:0] ix;
		logic acc;
		logic any;
		logic b;
		logic r;
		logic fire;
		logic [5:0] src;
		logic [2:0] rel;
		logic [31:0] v;
		logic [24:0] lim;
		logic [3:0] restart;
		logic [3:0] tgt;
		ix = '0;
		acc = 1'b0;
		any = 1'b0;
		b = 1'b0;
		r = 1'b0;
		fire = 1'b0;
		src = '0;
		rel = '0;
		v = '0;
		lim = '0;
		restart = '0;
		tgt = '0;
		next_st = st;
		next_st.rec = '0;
		next_st.pprev = pulse_src;
		next_st.scnt = scan ? '0 : st.scnt + 17'h1;
		// Register writes
		if (reg_wr) begin
			if (hit(reg_addr, `SLC_A_TCTL, NT)) begin
				ix = reg_addr - `SLC_A_TCTL;
				if (32'(ix) < NT - 4) begin
					next_st.tctl[ix[5:0]] = reg_wdata[15:0]; // see RULE10
				end
			end
			if (hit(reg_addr, `SLC_A_TOP, NT)) begin
				ix = reg_addr - `SLC_A_TOP;
				if (32'(ix) < NT - 4) begin
					next_st.top[ix[5:0]] = reg_wdata;
				end else if (32'(ix) == NT - 4 &&
					reg_wdata >= `SLC_LIMIT_MIN &&
					reg_wdata <= `SLC_LIMIT_MAX) begin
					next_st.top[ix[5:0]] = reg_wdata; // see RULE10
				end
			end
			if (hit(reg_addr, `SLC_A_TREL, NT)) begin
				ix = reg_addr - `SLC_A_TREL;
				if (32'(ix) < NT - 4) begin
					next_st.trel[ix[5:0]] = reg_wdata; // see RULE13
				end
			end
			if (hit(reg_addr, `SLC_A_ACT, NT)) begin
				ix = reg_addr - `SLC_A_ACT;
				if (32'(ix) < NT - 4) begin
					next_st.act[ix[5:0]] = reg_wdata[6:0];
				end
			end
			if (hit(reg_addr, `SLC_A_DOP, N_SP)) begin
				ix = reg_addr - `SLC_A_DOP;
				if (32'(ix) < N_SP - 1) begin
					next_st.dop[ix[3:0]] = reg_wdata[23:0]; // see RULE6
				end
			end
			if (hit(reg_addr, `SLC_A_DREL, N_SP)) begin
				ix = reg_addr - `SLC_A_DREL;
				if (32'(ix) < N_SP - 1) begin
					next_st.drel[ix[3:0]] = reg_wdata[23:0]; // see RULE7
				end
			end
			if (hit(reg_addr, `SLC_A_TPER, 4)) begin
				ix = reg_addr - `SLC_A_TPER;
				next_st.tper[ix[1:0]] = reg_wdata[26:0];
				next_st.tel[ix[1:0]] = '0; // see RULE24
				next_st.tpend[ix[1:0]] = 1'b0;
			end
			if (reg_addr == `SLC_A_FLAGS) begin
				next_st.flags = reg_wdata[7:0]; // see RULE18
			end
			if (reg_addr == `SLC_A_ALARM) begin
				next_st.alarm = st.alarm & ~reg_wdata[N_SP-1:0];
			end
			if (reg_addr == `SLC_A_CTRL) begin
				next_st.line50 = reg_wdata[0];
				next_st.scnt = '0;
			end
			if (hit(reg_addr, `SLC_A_CNT, 8)) begin
				ix = reg_addr - `SLC_A_CNT;
				next_st.cnt[ix[2:0]] = reg_wdata;
			end
		end
		// Scan of all setpoints
		if (scan) begin
			for (int t = 0; t < 4; t++) begin
				next_st.tpend[t] = 1'b0; // see RULE17
				if (next_st.tper[t] == '0) begin
					next_st.tel[t] = '0; // see RULE24
				end else if (st.tel[t] + 27'(step) >= next_st.tper[t]) begin
					next_st.tel[t] = '0;
					next_st.tpend[t] = 1'b1; // see RULE19
				end else begin
					next_st.tel[t] = st.tel[t] + 27'(step);
				end
			end
			for (int s = 0; s < N_SP; s++) begin
				acc = 1'b0;
				any = 1'b0;
				restart = '0;
				for (int k = 0; k < 4; k++) begin
					src = st.tctl[s*4+k][5:0];
					rel = st.tctl[s*4+k][`SLC_TCTL_REL_LSB +: 3];
					v = analog_val[32*int'(src[2:0]) +: 32];
					if (src < SRC_PULSE) begin
						b = din[src[3:0]]; // see RULE15
					end else if (src < SRC_FLAG) begin
						b = st.ppend[src[2:0]]; // see RULE16
					end else if (src < SRC_TIMER) begin
						b = st.flags[src[2:0]]; // see RULE18
					end else if (src < SRC_TIME) begin
						b = st.tpend[src[1:0]];
						restart[src[1:0]] = 1'b1;
					end else if (src == SRC_TIME) begin
						b = st.top[s*4+k][5:0] != 6'h0 &&
							minute_of_hour % st.top[s*4+k][5:0] == 6'h0;
					end else begin
						b = v != '0;
					end
					if (src[5:3] == 3'h5) begin
						unique case (rel) // see RULE4
							REL_LE: r = st.hyst[s*4+k] ?
								$signed(v) < $signed(st.trel[s*4+k]) :
								$signed(v) <= $signed(st.top[s*4+k]);
							REL_GE: r = st.hyst[s*4+k] ?
								$signed(v) > $signed(st.trel[s*4+k]) :
								$signed(v) >= $signed(st.top[s*4+k]); // see RULE26
							REL_EQ: r = v == st.top[s*4+k];
							REL_OFF: r = !b;
							default: r = b;
						endcase
						next_st.hyst[s*4+k] = r; // see RULE5
					end else begin
						r = (rel == REL_OFF) ? !b : b; // see RULE14
						next_st.hyst[s*4+k] = 1'b0;
					end
					if (src != SRC_NONE) begin
						if (!any) begin
							acc = r; // see RULE25
						end else if (!st.tctl[s*4+k][`SLC_TCTL_OP_BIT]) begin
							acc = acc | r; // see RULE11
						end else begin
							acc = acc & r; // see RULE12
						end
						any = 1'b1; // see RULE2
					end
				end
				lim = {1'b0, st.status[s] ? st.drel[s] : st.dop[s]};
				fire = 1'b0;
				if (acc != st.status[s]) begin
					if ({1'b0, st.elap[s]} + 25'(step) > lim) begin
						next_st.status[s] = acc; // see RULE21
						next_st.elap[s] = '0;
						fire = acc;
					end else begin
						next_st.elap[s] = st.elap[s] + 24'(step); // see RULE22
					end
				end else begin
					next_st.elap[s] = '0;
				end
				if (fire) begin
					for (int t = 0; t < 4; t++) begin
						if (restart[t]) begin
							next_st.tel[t] = '0; // see RULE20
						end
					end
					for (int a = 0; a < 4; a++) begin
						tgt = st.act[s*4+a][3:0];
						unique case (st.act[s*4+a][`SLC_ACT_TYPE_LSB +: 3])
							ACT_CNT_INC: next_st.cnt[tgt[2:0]] =
								next_st.cnt[tgt[2:0]] + 32'h1; // see RULE3
							ACT_CNT_DEC: next_st.cnt[tgt[2:0]] =
								next_st.cnt[tgt[2:0]] - 32'h1;
							ACT_RECORD: next_st.rec[tgt] = 1'b1; // see RULE9
							ACT_FLAG_SET: next_st.flags[tgt[2:0]] = 1'b1;
							ACT_FLAG_CLR: next_st.flags[tgt[2:0]] = 1'b0;
							default: next_st.rec = next_st.rec;
						endcase
					end
				end
			end
			next_st.ppend = rise; // see RULE17
		end else begin
			next_st.ppend = st.ppend | rise; // see RULE16
		end
		// Relays follow the OR of their operated setpoints
		next_st.relay = '0;
		for (int s = 0; s < N_SP; s++) begin // see RULE1
			for (int a = 0; a < 4; a++) begin
				if (next_st.status[s] &&
					st.act[s*4+a][`SLC_ACT_TYPE_LSB +: 3] == ACT_RELAY) begin
					next_st.relay[st.act[s*4+a][2:0]] = 1'b1; // see RULE3
				end
			end
		end
		next_st.alarm = next_st.alarm | next_st.status; // see RULE23
		// Register reads
		next_st.rdata = '0;
		if (reg_rd) begin
			if (hit(reg_addr, `SLC_A_TCTL, NT)) begin
				ix = reg_addr - `SLC_A_TCTL;
				next_st.rdata = {16'h0, st.tctl[ix[5:0]]};
			end
			if (hit(reg_addr, `SLC_A_TOP, NT)) begin
				ix = reg_addr - `SLC_A_TOP;
				next_st.rdata = st.top[ix[5:0]];
			end
			if (hit(reg_addr, `SLC_A_TREL, NT)) begin
				ix = reg_addr - `SLC_A_TREL;
				next_st.rdata = st.trel[ix[5:0]];
			end
			if (hit(reg_addr, `SLC_A_ACT, NT)) begin
				ix = reg_addr - `SLC_A_ACT;
				next_st.rdata = {25'h0, st.act[ix[5:0]]};
			end
			if (hit(reg_addr, `SLC_A_DOP, N_SP)) begin
				ix = reg_addr - `SLC_A_DOP;
				next_st.rdata = {8'h0, st.dop[ix[3:0]]};
			end
			if (hit(reg_addr, `SLC_A_DREL, N_SP)) begin
				ix = reg_addr - `SLC_A_DREL;
				next_st.rdata = {8'h0, st.drel[ix[3:0]]};
			end
			if (hit(reg_addr, `SLC_A_TPER, 4)) begin
				ix = reg_addr - `SLC_A_TPER;
				next_st.rdata = {5'h0, st.tper[ix[1:0]]};
			end
			if (reg_addr == `SLC_A_FLAGS) begin
				next_st.rdata = {24'h0, st.flags};
			end
			if (reg_addr == `SLC_A_STATUS) begin
				next_st.rdata = 32'(st.status);
			end
			if (reg_addr == `SLC_A_ALARM) begin
				next_st.rdata = 32'(st.alarm);
			end
			if (reg_addr == `SLC_A_CTRL) begin
				next_st.rdata = {31'h0, st.line50};
			end
			if (hit(reg_addr, `SLC_A_CNT, 8)) begin
				ix = reg_addr - `SLC_A_CNT;
				next_st.rdata = st.cnt[ix[2:0]];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= RESET_ST;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign relay_out = st.relay;
	assign rec_trig = st.rec;
	assign sp_status = st.status;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_status_on_scan: assert property ( // see RULE8
		st.status != $past(st.status) |-> $past(scan))
		else $error("Setpoint status changed outside a scan");
	a_alarm_latches: assert property ( // see RULE23
		(st.status & ~st.alarm) == '0)
		else $error("Operated setpoint missing from alarm latch");
	a_edge_caught: assert property ( // see RULE16
		!scan && rise != '0 |=> (st.ppend & $past(rise)) == $past(rise))
		else $error("Pulse source edge not captured");
	a_pulse_cleared: assert property ( // see RULE17
		scan && rise == '0 |=> st.ppend == '0)
		else $error("Pulsed event survived the end of scan");
	a_last_protected: assert property ( // see RULE10
		reg_wr && reg_addr == `SLC_A_TCTL + 10'(NT - 4) |=>
		$stable(st.tctl[NT-4]))
		else $error("Protected setpoint configuration changed");
	a_timer_stopped: assert property ( // see RULE24
		st.tper[0] == '0 && $past(st.tper[0]) == '0 |-> st.tel[0] == '0
		&& !st.tpend[0])
		else $error("Stopped timer is running");
	a_flag_read: assert property ( // see RULE18
		reg_rd && reg_addr == `SLC_A_FLAGS |=>
		reg_rdata == {24'h0, $past(st.flags)})
		else $error("Flag read data wrong");
	a_relay_idle: assert property ( // see RULE3
		st.status == '0 |-> relay_out == '0)
		else $error("Relay driven with no operated setpoint");
	a_scan_spacing: assert property ( // see RULE8
		scan |=> !scan [*8])
		else $error("Scans too close together");
endmodule // setpoint_logic_controller

/* File: rtl/slc_cfg.svh */
// Address map, reset values and timing constants of the setpoint controller
`ifndef SLC_CFG_SVH
`define SLC_CFG_SVH
`define SLC_CLK_NS 100
`define SLC_SCAN_60_NS 8000000
`define SLC_SCAN_50_NS 10000000
`define SLC_SCAN_60_MS 8
`define SLC_SCAN_50_MS 10
`define SLC_A_TCTL 10'h000
`define SLC_A_TOP 10'h040
`define SLC_A_TREL 10'h080
`define SLC_A_ACT 10'h0c0
`define SLC_A_DOP 10'h100
`define SLC_A_DREL 10'h110
`define SLC_A_TPER 10'h120
`define SLC_A_FLAGS 10'h124
`define SLC_A_STATUS 10'h125
`define SLC_A_ALARM 10'h126
`define SLC_A_CTRL 10'h127
`define SLC_A_CNT 10'h128
`define SLC_TCTL_OP_BIT 15
`define SLC_TCTL_REL_LSB 12
`define SLC_ACT_TYPE_LSB 4
`define SLC_RST_TCTL 16'h003f
`define SLC_RST_TIME_TCTL 16'h3024
`define SLC_RST_TIME_MIN 32'h0000000f
`define SLC_RST_ACT_REC0 7'h40
`define SLC_RST_ACT_REC1 7'h41
`define SLC_RST_ACT_REC11 7'h4b
`define SLC_LIMIT_MIN 32'h00000001
`define SLC_LIMIT_MAX 32'h0000003c
`endif

/* File: rtl/slc_pkg.sv */
// Types shared by the setpoint controller
package slc_pkg;
	typedef enum logic [2:0] {
		REL_LE = 3'h0,
		REL_GE = 3'h1,
		REL_EQ = 3'h2,
		REL_ON = 3'h3,
		REL_OFF = 3'h4
	} relation_type;
	typedef enum logic [2:0] {
		ACT_NONE = 3'h0,
		ACT_RELAY = 3'h1,
		ACT_CNT_INC = 3'h2,
		ACT_CNT_DEC = 3'h3,
		ACT_RECORD = 3'h4,
		ACT_FLAG_SET = 3'h5,
		ACT_FLAG_CLR = 3'h6
	} action_type;
	typedef enum logic [5:0] {
		SRC_DIN = 6'h00,
		SRC_PULSE = 6'h10,
		SRC_FLAG = 6'h18,
		SRC_TIMER = 6'h20,
		SRC_TIME = 6'h24,
		SRC_ANALOG = 6'h28,
		SRC_NONE = 6'h3f
	} source_type;
endpackage

/* File: bench/tb_top.sv */
// Self-checking testbench of the setpoint logical controller
module tb_top import slc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// ********************
	// Signals and clock
	// ********************
	logic clk, rst, reg_wr, reg_rd;
	logic [9:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv, seed;
	logic [15:0] din, sp_status, rec_trig, rec_seen;
	logic [7:0] pulse_src, relay_out;
	logic [255:0] analog_val;
	logic [5:0] minute_of_hour;
	logic [3:0] ops, ons;
	logic e;
	int mismatches, check_count;
	int gv[5] = '{120, 70, 50, 70, 100};
	logic ge[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
	logic [31:0] lw[4] = '{32'h0, 32'h3d, 32'h3c, 32'h1};
	logic [31:0] le[4] = '{32'hf, 32'hf, 32'h3c, 32'h1};
	setpoint_logic_controller #(.SCAN_60_CYCLES(20), .SCAN_50_CYCLES(25)) uut (
		.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .din(din),
		.pulse_src(pulse_src), .analog_val(analog_val),
		.minute_of_hour(minute_of_hour), .relay_out(relay_out),
		.rec_trig(rec_trig), .sp_status(sp_status));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Sticky record of every recorder trigger pulse
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rec_seen <= '0;
		end else begin
			rec_seen <= rec_seen | rec_trig;
		end
	end
	// ********************
	// Tasks and functions
	// ********************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic scans(input int n);
		repeat (n * 20) @(posedge clk);
	endtask
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic ev(input logic [3:0] op, input logic [3:0] on,
		input logic [3:0] d);
		logic acc;
		acc = (d[0] == on[0]);
		for (int k = 1; k < 4; k++) begin
			acc = op[k] ? (acc & (d[k] == on[k])) : (acc | (d[k] == on[k]));
		end
		return acc;
	endfunction
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#5000000;
		mismatches++;
		stop_test();
	end
	// ********************
	// Main sequence
	// ********************
	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 10'h000;
		reg_wdata = 32'h0;
		din = 16'h0000;
		pulse_src = 8'h00;
		analog_val = '0;
		minute_of_hour = 6'h00;
		seed = 32'h44046ca6;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(10'h000, rv);
		chk(rv, 32'h3024);
		@(posedge clk);
		#1 chk(reg_rdata, 32'h0);
		rd(10'h0c1, rv);
		chk(rv, 32'h41);
		rd(10'h3ff, rv);
		chk(rv, 32'h0);
		scans(3);
		chk(sp_status[0], 1'b1);
		chk(rec_seen, 32'h0803);
		minute_of_hour <= 6'h07;
		scans(3);
		chk(sp_status[0], 1'b0);
		// Setpoint sixteen keeps its setup, limit 1..60 only
		wr(10'h03c, 32'h0);
		rd(10'h03c, rv);
		chk(rv, 32'h3024);
		wr(10'h10f, 32'h5);
		rd(10'h10f, rv);
		chk(rv, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(10'h07c, lw[i]);
			rd(10'h07c, rv);
			chk(rv, le[i]);
		end
		wr(10'h124, 32'ha5);
		rd(10'h124, rv);
		chk(rv, 32'ha5);
		// Random OR/AND expressions of four binary triggers
		wr(10'h0c4, 32'h13);
		for (int i = 0; i < 24; i++) begin
			seed = xs(seed);
			ops = seed[3:0];
			ons = seed[7:4];
			for (int k = 0; k < 4; k++) begin
				wr(10'h004 + 10'(k), {16'h0, ops[k], ons[k] ? 3'h3 : 3'h4,
					6'h0, 6'(k)});
			end
			din <= {12'h0, seed[11:8]};
			e = ev(ops, ons, seed[11:8]);
			scans(3);
			chk(sp_status[1], e);
			chk(relay_out[3], e);
		end
		// Operate delay of 20 ms needs three scans of 8 ms
		wr(10'h004, 32'h3000);
		for (int k = 1; k < 4; k++) begin
			wr(10'h004 + 10'(k), 32'h3f);
		end
		wr(10'h101, 32'd20);
		din <= 16'h0000;
		scans(3);
		din <= 16'h0001;
		repeat (15) @(posedge clk);
		chk(sp_status[1], 1'b0);
		repeat (65) @(posedge clk);
		chk(sp_status[1], 1'b1);
		din <= 16'h0000;
		scans(3);
		chk(sp_status[1], 1'b0);
		rd(10'h126, rv);
		chk(rv[1], 1'b1);
		wr(10'h126, 32'h2);
		rd(10'h126, rv);
		chk(rv[1], 1'b0);
		// Analog greater-equal with hysteresis
		wr(10'h00c, 32'h1028);
		wr(10'h04c, 32'd100);
		wr(10'h08c, 32'd50);
		for (int i = 0; i < 5; i++) begin
			analog_val[31:0] <= gv[i];
			scans(3);
			chk(sp_status[3], ge[i]);
		end
		// Interval timer counted through a setpoint
		wr(10'h008, 32'h3020);
		wr(10'h0c8, 32'h20);
		scans(6);
		rd(10'h128, rv);
		chk(rv, 32'h0);
		wr(10'h120, 32'd16);
		scans(12);
		rd(10'h128, rv);
		chk(rv != 32'h0, 1'b1);
		// 50 Hz scan; pulse sets a flag, flag setpoint clears it
		wr(10'h127, 32'h1);
		rd(10'h127, rv);
		chk(rv, 32'h1);
		wr(10'h014, 32'h301b);
		wr(10'h0d4, 32'h63);
		wr(10'h0d5, 32'h22);
		wr(10'h010, 32'h3010);
		wr(10'h0d0, 32'h53);
		wr(10'h0d1, 32'h31);
		pulse_src <= 8'h01;
		scans(6);
		rd(10'h124, rv);
		chk(rv, 32'ha5);
		rd(10'h129, rv);
		chk(rv, 32'hffffffff);
		rd(10'h12a, rv);
		chk(rv, 32'h1);
		stop_test();
	end
endmodule // tb_top
